// File: hw/cg_defines.svh
`ifndef CG_DEFINES_SVH
`define CG_DEFINES_SVH

// group shape
`define CG_NUM_CELLS   10
`define CG_CTRL_CELL   0
`define CG_FIRST_CHAIN 1
`define CG_LAST_CELL   9
`define CG_LUT_IN      4
`define CG_LUT_W       16

// clock and clear source vector
`define CG_NUM_GLB     4
`define CG_NUM_PIN     4
`define CG_NUM_SRC     32
`define CG_SRC_W       5
`define CG_SRC_PAD     14

// input positions inside a cell
`define CG_OPA_IN      0
`define CG_OPB_IN      1
`define CG_KR_IN       2
`define CG_LDVAL_IN    3
`define CG_SCLR_IN     0
`define CG_SLOAD_IN    1

// reset and chain idle values
`define CG_Q_RST       1'h0
`define CG_CARRY_IDLE  1'h0
`define CG_AND_IDLE    1'h1
`define CG_OR_IDLE     1'h0

`endif

// File: hw/cg_pkg.sv
package cg_pkg;

	typedef enum logic [1:0] {
		CG_FF_D  = 2'h0,
		CG_FF_T  = 2'h1,
		CG_FF_JK = 2'h2,
		CG_FF_SR = 2'h3
	} cg_ff_mode_e;

	typedef enum logic [1:0] {
		CG_CASC_NONE = 2'h0,
		CG_CASC_AND  = 2'h1,
		CG_CASC_OR   = 2'h2
	} cg_casc_e;

endpackage : cg_pkg

// File: hw/cg_src_sel.sv
`timescale 1ns/1ps
`include "cg_defines.svh"

module cg_src_sel (
	// source lines
	input  wire logic [`CG_NUM_SRC-1:0] src,
	// selection
	input  wire logic [`CG_SRC_W-1:0]   sel,
	// chosen line
	output logic                        line
);

	always_comb begin
		line = src[sel];
	end

endmodule : cg_src_sel

// File: hw/cg_cell.sv
`timescale 1ns/1ps
`include "cg_defines.svh"

module cg_cell (
	// clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst_b,
	// configuration
	input  wire logic [`CG_LUT_W-1:0]  lut_mask,
	input  wire cg_pkg::cg_ff_mode_e   ff_mode,
	input  wire cg_pkg::cg_casc_e      casc_mode,
	input  wire logic                  arith,
	input  wire logic                  bypass,
	// data and chains
	input  wire logic [`CG_LUT_IN-1:0] data,
	input  wire logic                  carry_in,
	input  wire logic                  casc_in,
	// control
	input  wire logic                  clk_src,
	input  wire logic                  clr_src,
	input  wire logic                  grp_sclr,
	input  wire logic                  grp_sload,
	// outputs
	output logic                       carry_out,
	output logic                       casc_out,
	output logic                       q,
	output logic                       local_out,
	output logic                       row_out
);

	logic sum;
	logic f;
	logic nxt;
	logic edge_hit;
	logic q_q;
	logic q_d;
	logic prev_q;
	logic prev_d;

	// lookup table, sum and carry halves in arithmetic use
	always_comb begin
		if (arith) begin
			sum       = lut_mask[{1'h0, carry_in, data[`CG_OPB_IN], data[`CG_OPA_IN]}];
			carry_out = lut_mask[{1'h1, carry_in, data[`CG_OPB_IN], data[`CG_OPA_IN]}];
		end else begin
			sum       = lut_mask[data];
			carry_out = carry_in;
		end
		case (casc_mode)
			cg_pkg::CG_CASC_AND: f = sum & casc_in;
			cg_pkg::CG_CASC_OR:  f = ~(~sum & ~casc_in);
			default:             f = sum;
		endcase
		casc_out = f;
	end

	// storage behaviour
	always_comb begin
		edge_hit = clk_src & ~prev_q;
		prev_d   = clk_src;
		case (ff_mode)
			cg_pkg::CG_FF_T:  nxt = q_q ^ f;
			cg_pkg::CG_FF_JK: nxt = (f & ~q_q) | (~data[`CG_KR_IN] & q_q);
			cg_pkg::CG_FF_SR: nxt = ~data[`CG_KR_IN] & (f | q_q);
			default:          nxt = f;
		endcase
		if (clr_src) begin
			q_d = `CG_Q_RST;
		end else if (edge_hit) begin
			if (grp_sclr) begin
				q_d = `CG_Q_RST;
			end else if (grp_sload) begin
				q_d = data[`CG_LDVAL_IN];
			end else begin
				q_d = nxt;
			end
		end else begin
			q_d = q_q;
		end
		q         = q_q;
		local_out = bypass ? f : (clr_src ? `CG_Q_RST : q_q);
		row_out   = local_out;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			q_q    <= `CG_Q_RST;
			prev_q <= 1'h0;
		end else begin
			q_q    <= q_d;
			prev_q <= prev_d;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	clr_forces_a: assert property (clr_src |-> (bypass || local_out == `CG_Q_RST) ##1 (q == `CG_Q_RST))
		else $error("clear did not force register low");
	// first cycle after reset is skipped: source history restarts low there
	hold_no_edge_a: assert property ($past(rst_b) && !clr_src && !(clk_src && !$past(clk_src))
		|=> q_q == $past(q_q))
		else $error("register changed without clock edge");
	sclr_cell_a: assert property (edge_hit && grp_sclr && !clr_src |=> q_q == 1'h0)
		else $error("group clear missed a register");
	toggle_mode_a: assert property (edge_hit && !clr_src && !grp_sclr && !grp_sload
		&& ff_mode == cg_pkg::CG_FF_T && f |=> q_q != $past(q_q))
		else $error("toggle register did not toggle");
	bypass_path_a: assert property (bypass |-> local_out == casc_out)
		else $error("bypass did not pass table result");

endmodule : cg_cell

// File: hw/cg_group.sv
`timescale 1ns/1ps
`include "cg_defines.svh"

// Summary of operation
// - each cell has a four-input table, one register, carry and cascade paths.
// - a group holds exactly ten cells sharing control and local routing.
// - each register acts as D, T, JK or SR storage per cell.
// - register clock and clear come from globals, pins or internal logic.
// - combinational cells bypass the register; table result drives outputs.
// - each cell output drives local and row/column routing together.
// - carry and cascade link cells two to ten and neighbouring groups.
// - incoming carry feeds the table and the next carry stage.
// - the first cell is kept out of the chains for control use.
// - first cell inputs produce group synchronous clear and load enable.
// - group synchronous clear and load act on every register.
// - arithmetic: one table half makes sum, the other makes carry.
// - cascade joins neighbours by AND, or OR through inversion.

module cg_group (
	// clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst_b,
	// global lines and pins
	input  wire logic [`CG_NUM_GLB-1:0] glb_line,
	input  wire logic [`CG_NUM_PIN-1:0] pin_in,
	// per cell configuration
	input  wire logic [`CG_LUT_W-1:0]  lut_mask  [`CG_NUM_CELLS],
	input  wire cg_pkg::cg_ff_mode_e   ff_mode   [`CG_NUM_CELLS],
	input  wire logic [`CG_NUM_CELLS-1:0] arith,
	input  wire logic [`CG_NUM_CELLS-1:0] bypass,
	input  wire logic [`CG_SRC_W-1:0]  clk_sel   [`CG_NUM_CELLS],
	input  wire logic [`CG_SRC_W-1:0]  clr_sel   [`CG_NUM_CELLS],
	// group configuration
	input  wire cg_pkg::cg_casc_e      casc_mode,
	input  wire logic                  sclr_en,
	input  wire logic                  sload_en,
	// cell inputs
	input  wire logic [`CG_LUT_IN-1:0] cell_data [`CG_NUM_CELLS],
	// chains from the lower neighbour
	input  wire logic                  carry_in,
	input  wire logic                  casc_in,
	// chains to the higher neighbour
	output logic                       carry_out,
	output logic                       casc_out,
	// group control
	output logic                       grp_sclr,
	output logic                       grp_sload,
	// cell outputs
	output logic [`CG_NUM_CELLS-1:0]   local_out,
	output logic [`CG_NUM_CELLS-1:0]   row_out,
	output logic [`CG_NUM_CELLS-1:0]   cell_q
);

	logic [`CG_NUM_SRC-1:0]   src_vec;
	logic [`CG_NUM_CELLS-1:0] reg_q;
	logic [`CG_NUM_CELLS-1:0] clk_line;
	logic [`CG_NUM_CELLS-1:0] clr_line;
	logic [`CG_NUM_CELLS-1:0] carry_i;
	logic [`CG_NUM_CELLS-1:0] carry_o;
	logic [`CG_NUM_CELLS-1:0] casc_i;
	logic [`CG_NUM_CELLS-1:0] casc_o;
	cg_pkg::cg_casc_e         cell_casc [`CG_NUM_CELLS];
	logic                     casc_idle;

	// sources: globals, pins, then raw registers; raw keeps the clear gate out of a loop
	always_comb begin
		src_vec = {{`CG_SRC_PAD{1'h0}}, reg_q, pin_in, glb_line};
		cell_q  = reg_q & ~clr_line;
	end

	// group control from the first cell's inputs
	always_comb begin
		grp_sclr  = sclr_en & cell_data[`CG_CTRL_CELL][`CG_SCLR_IN];
		grp_sload = sload_en & cell_data[`CG_CTRL_CELL][`CG_SLOAD_IN];
	end

	// chain wiring; first cell sees idle values and no cascade
	always_comb begin
		casc_idle = (casc_mode == cg_pkg::CG_CASC_AND) ? `CG_AND_IDLE : `CG_OR_IDLE;
		for (int i = 0; i < `CG_NUM_CELLS; i++) begin
			if (i == `CG_CTRL_CELL) begin
				carry_i[i]   = `CG_CARRY_IDLE;
				casc_i[i]    = casc_idle;
				cell_casc[i] = cg_pkg::CG_CASC_NONE;
			end else if (i == `CG_FIRST_CHAIN) begin
				carry_i[i]   = carry_in;
				casc_i[i]    = casc_in;
				cell_casc[i] = casc_mode;
			end else begin
				carry_i[i]   = carry_o[i-1];
				casc_i[i]    = casc_o[i-1];
				cell_casc[i] = casc_mode;
			end
		end
		carry_out = carry_o[`CG_LAST_CELL];
		casc_out  = casc_o[`CG_LAST_CELL];
	end

	// ten cells, each with its own clock and clear pick
	for (genvar g = 0; g < `CG_NUM_CELLS; g++) begin : g_cell
		cg_src_sel u_clk_sel (
			.src  (src_vec),
			.sel  (clk_sel[g]),
			.line (clk_line[g])
		);

		cg_src_sel u_clr_sel (
			.src  (src_vec),
			.sel  (clr_sel[g]),
			.line (clr_line[g])
		);

		cg_cell u_cell (
			.sys_clk   (sys_clk),
			.rst_b     (rst_b),
			.lut_mask  (lut_mask[g]),
			.ff_mode   (ff_mode[g]),
			.casc_mode (cell_casc[g]),
			.arith     (arith[g]),
			.bypass    (bypass[g]),
			.data      (cell_data[g]),
			.carry_in  (carry_i[g]),
			.casc_in   (casc_i[g]),
			.clk_src   (clk_line[g]),
			.clr_src   (clr_line[g]),
			.grp_sclr  (grp_sclr),
			.grp_sload (grp_sload),
			.carry_out (carry_o[g]),
			.casc_out  (casc_o[g]),
			.q         (reg_q[g]),
			.local_out (local_out[g]),
			.row_out   (row_out[g])
		);
	end

	// checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	logic                     all_low;
	logic [`CG_NUM_CELLS-1:0] ld_val;
	always_comb begin
		all_low = (cell_q == '0);
		for (int i = 0; i < `CG_NUM_CELLS; i++) begin
			ld_val[i] = cell_data[i][`CG_LDVAL_IN];
		end
	end

	sequence load_all_s;
		grp_sload && !grp_sclr && (clr_line == '0) && (clk_line == '1) && ($past(clk_line) == '0);
	endsequence

	sequence clr_all_s;
		grp_sclr && (clr_line == '0) && (clk_line == '1) && ($past(clk_line) == '0);
	endsequence

	sequence regs_low_s;
		all_low;
	endsequence

	dual_drive_a: assert property (local_out == row_out)
		else $error("local and row outputs differ");

	ctrl_gen_a: assert property (grp_sclr == (sclr_en && cell_data[`CG_CTRL_CELL][`CG_SCLR_IN])
		&& grp_sload == (sload_en && cell_data[`CG_CTRL_CELL][`CG_SLOAD_IN]))
		else $error("group control not from first cell");

	ctrl_excl_a: assert property ($changed(carry_in) |-> $stable(carry_o[`CG_CTRL_CELL]))
		else $error("first cell joined the carry chain");

	group_clr_a: assert property (clr_all_s |=> regs_low_s)
		else $error("group clear left a register set");

	load_all_a: assert property (load_all_s |=> cell_q == $past(ld_val))
		else $error("group load missed a register");

	carry_pass_a: assert property ((arith == '0) |-> carry_out == carry_in)
		else $error("carry did not pass through the chain");

	and_chain_a: assert property (casc_mode == cg_pkg::CG_CASC_AND && !casc_in
		&& (arith == '0) |-> !casc_out)
		else $error("and cascade passed a low input");

	or_chain_a: assert property (casc_mode == cg_pkg::CG_CASC_OR && casc_in
		&& (arith == '0) |-> casc_out)
		else $error("or cascade dropped a high input");

	clr_now_a: assert property ((clr_line != '0)
		|-> ((cell_q | (local_out & ~bypass)) & clr_line) == '0)
		else $error("cleared register still high");

endmodule : cg_group

// File: verif/cg_nbr_model.sv
`timescale 1ns/1ps

module cg_nbr_model (
	// chain control
	input  wire cg_pkg::cg_casc_e casc_mode,
	input  wire logic             carry_gen,
	input  wire logic             casc_kill,
	// chains into the group
	output logic                  carry_in,
	output logic                  casc_in
);
	// lower group carry out
	assign carry_in = carry_gen;
	// idle level unless a bad neighbour is asked for
	assign casc_in = (casc_mode == cg_pkg::CG_CASC_OR) ? casc_kill : ~casc_kill;
endmodule : cg_nbr_model

// File: verif/cg_group_tb_top.sv
`timescale 1ns/1ps

module cg_group_tb_top;
	typedef struct packed {
		logic       clr;
		logic [1:0] mode;
		logic [3:0] din;
		logic       exp;
	} cg_row_s;
	logic                sys_clk;
	logic                rst_b;
	logic [7:0]          src;
	logic [15:0]         lut_mask [10];
	cg_pkg::cg_ff_mode_e ff_mode [10];
	logic [9:0]          arith;
	logic [9:0]          bypass;
	logic [4:0]          clk_sel [10];
	logic [4:0]          clr_sel [10];
	cg_pkg::cg_casc_e    casc_mode;
	logic                sclr_en;
	logic                sload_en;
	logic [3:0]          cell_data [10];
	logic                carry_gen;
	logic                casc_kill;
	logic                carry_in;
	logic                casc_in;
	logic                carry_out;
	logic                casc_out;
	logic                grp_sclr;
	logic                grp_sload;
	logic [9:0]          local_out;
	logic [9:0]          row_out;
	logic [9:0]          cell_q;
	int                  bad_count;
	int                  checked;
	// clr, mode, data, expected q
	cg_row_s rows [13] = '{8'h83, 8'h00, 8'ha3, 8'h21, 8'h22, 8'hc3, 8'h4a, 8'h48, 8'h4b, 8'h41, 8'he3, 8'h61, 8'h6a};

	cg_nbr_model nbr (.casc_mode(casc_mode), .carry_gen(carry_gen), .casc_kill(casc_kill),
		.carry_in(carry_in), .casc_in(casc_in));
	cg_group dut (.sys_clk(sys_clk), .rst_b(rst_b), .glb_line(src[3:0]), .pin_in(src[7:4]),
		.lut_mask(lut_mask), .ff_mode(ff_mode), .arith(arith), .bypass(bypass), .clk_sel(clk_sel),
		.clr_sel(clr_sel), .casc_mode(casc_mode), .sclr_en(sclr_en), .sload_en(sload_en),
		.cell_data(cell_data), .carry_in(carry_in), .casc_in(casc_in), .carry_out(carry_out),
		.casc_out(casc_out), .grp_sclr(grp_sclr), .grp_sload(grp_sload), .local_out(local_out),
		.row_out(row_out), .cell_q(cell_q));

	task automatic step;
		@(posedge sys_clk);
		#1;
	endtask : step
	task automatic pulse(input int idx);
		src[idx] = 1'h1;
		step;
		src[idx] = 1'h0;
		step;
	endtask : pulse
	task automatic chk(input string name, input logic [9:0] seen, input logic [9:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic fill(input logic [15:0] m, input logic [3:0] d);
		for (int i = 0; i < 10; i++) begin
			lut_mask[i] = m;
			cell_data[i] = d;
		end
	endtask : fill
	task automatic set_mode(input cg_pkg::cg_ff_mode_e m);
		foreach (ff_mode[i]) ff_mode[i] = m;
	endtask : set_mode
	task automatic add_chk(input logic [8:0] a, input logic [8:0] b, input logic cin);
		logic [9:0] s;
		s = {1'h0, a} + {1'h0, b} + {9'h0, cin};
		step;
		carry_gen = cin;
		for (int i = 1; i < 10; i++) cell_data[i] = {2'h0, b[i-1], a[i-1]};
		#1;
		chk("sum", local_out, {s[8:0], 1'h0});
		chk("row", row_out, {s[8:0], 1'h0});
		chk("carry", {9'h0, carry_out}, {9'h0, s[9]});
	endtask : add_chk
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run

	initial begin
		sys_clk = 1'h0;
		forever #20 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (1000) @(posedge sys_clk);
		bad_count++;
		complete_run;
	end
	initial begin
		bad_count = 0;
		checked = 0;
		rst_b = 1'h0;
		src = 8'h00;
		casc_mode = cg_pkg::CG_CASC_NONE;
		{sclr_en, sload_en, carry_gen, casc_kill} = 4'h0;
		arith = 10'h000;
		bypass = 10'h000;
		set_mode(cg_pkg::CG_FF_D);
		foreach (clk_sel[i]) clk_sel[i] = 5'h00;
		foreach (clr_sel[i]) clr_sel[i] = 5'h01;
		fill(16'haaaa, 4'h0);
		repeat (16) step;
		chk("reset", cell_q, 10'h000);
		rst_b = 1'h1;
		fill(16'haaaa, 4'h1);
		repeat (3) step;
		chk("hold", cell_q, 10'h000);
		foreach (rows[r]) begin
			set_mode(cg_pkg::cg_ff_mode_e'(rows[r].mode));
			foreach (cell_data[i]) cell_data[i] = rows[r].din;
			if (rows[r].clr) pulse(1);
			pulse(0);
			chk("q", cell_q, {10{rows[r].exp}});
			chk("local", local_out, {10{rows[r].exp}});
		end
		// clear acts before any edge
		set_mode(cg_pkg::CG_FF_D);
		fill(16'haaaa, 4'h1);
		pulse(0);
		src[1] = 1'h1;
		#1;
		chk("clr", cell_q, 10'h000);
		step;
		src[1] = 1'h0;
		step;
		chk("clr", cell_q, 10'h000);
		foreach (clk_sel[i]) clk_sel[i] = 5'h04;
		pulse(4);
		fill(16'haaaa, 4'h0);
		pulse(0);
		chk("pin", cell_q, 10'h3ff);
		foreach (clk_sel[i]) clk_sel[i] = 5'h00;
		fill(16'haaaa, 4'h8);
		cell_data[0] = 4'ha;
		sload_en = 1'h1;
		pulse(1);
		pulse(0);
		chk("load", cell_q, 10'h3ff);
		chk("gload", {9'h0, grp_sload}, 10'h001);
		sclr_en = 1'h1;
		cell_data[0] = 4'hb;
		pulse(0);
		chk("sclr", cell_q, 10'h000);
		chk("gclr", {9'h0, grp_sclr}, 10'h001);
		{sclr_en, sload_en} = 2'h0;
		arith = 10'h3ff;
		bypass = 10'h3ff;
		fill(16'he896, 4'h3);
		add_chk(9'h1ff, 9'h001, 1'h0);
		add_chk(9'h155, 9'h0aa, 1'h1);
		add_chk(9'h000, 9'h000, 1'h1);
		add_chk(9'h1ff, 9'h1ff, 1'h1);
		arith = 10'h000;
		for (int m = 1; m < 3; m++) begin
			for (int k = 0; k < 11; k++) begin
				step;
				casc_mode = cg_pkg::cg_casc_e'(m[1:0]);
				fill((m == 1) ? 16'h8000 : 16'hfffe, (m == 1) ? 4'hf : 4'h0);
				casc_kill = (k == 10);
				if (k < 10) cell_data[k] = (m == 1) ? 4'h0 : 4'h1;
				#1;
				chk("casc", {9'h0, casc_out}, {9'h0, (m == 1) == (k == 0)});
			end
		end
		// reset in mid-run; a source already high counts as an edge at release
		casc_kill = 1'h0;
		casc_mode = cg_pkg::CG_CASC_NONE;
		bypass = 10'h000;
		fill(16'haaaa, 4'h1);
		pulse(0);
		chk("pre", cell_q, 10'h3ff);
		rst_b = 1'h0;
		src[0] = 1'h1;
		step;
		chk("reset", cell_q, 10'h000);
		step;
		rst_b = 1'h1;
		step;
		chk("release", cell_q, 10'h3ff);
		src[0] = 1'h0;
		step;
		complete_run;
	end
endmodule : cg_group_tb_top
